/* rtl/p9fs_consts.svh */
// Purpose: Named constants for the port 9 alternate-function select block
// Assumes: APB word slave, byte address = 4 * register index
// Notes:   Behaviour list follows
// Behaviour
// - Mode-control bits 15..8 reachable as bits 7..0 of its upper alias word.
// - Mode-control readable/writable as 16 bits and via lower/upper byte aliases.
// - Output-type bit clear gives push-pull, set gives N-channel open-drain, pins 8, 9.
// - Output-type bit 0 is pin 8, bit 1 pin 9; others zero; resets zero.
// - Mode set with function bit clear leaves the pin undriven; set function first.
// - Function bits 13, 14, 15 route pins to external interrupt inputs 4, 5, 6.
// - Function bits route pins 9,8,7,6,1,0 to CSI clock/out/in, timer, UART rx/tx.
// - Function-control bits 15..8 reachable as bits 7..0 of its upper alias word.
// - Function-control readable/writable as 16 bits and via lower/upper byte aliases.
// - Pin 1 with mode clear feeds port/key-return input, with mode and function bits both set UART receive.
`ifndef P9FS_CONSTS_SVH
`define P9FS_CONSTS_SVH

// Register word indices
`define P9FS_IDX_OTS      30'h0FFFFC73
`define P9FS_IDX_PMC      30'h0FFFFC40
`define P9FS_IDX_PMC_LO   30'h0FFFFC44
`define P9FS_IDX_PMC_HI   30'h0FFFFC45
`define P9FS_IDX_PFC      30'h0FFFFC48
`define P9FS_IDX_PFC_LO   30'h0FFFFC4C
`define P9FS_IDX_PFC_HI   30'h0FFFFC4D

// Implemented bits and reset values
`define P9FS_PIN_MASK     16'hE3C3
`define P9FS_OTS_MASK     8'h03
`define P9FS_PMC_RST      16'h0000
`define P9FS_PFC_RST      16'h0000
`define P9FS_OTS_RST      8'h00
`define P9FS_PERIPH_RST   8'h1F

// Pin positions
`define P9FS_PIN_TX       0
`define P9FS_PIN_RX       1
`define P9FS_PIN_TMR      6
`define P9FS_PIN_SIN      7
`define P9FS_PIN_SOUT     8
`define P9FS_PIN_SCK      9
`define P9FS_PIN_IRQ4     13
`define P9FS_PIN_IRQ5     14
`define P9FS_PIN_IRQ6     15
`define P9FS_OD_BASE      8

`endif

/* rtl/p9fs_pkg.sv */
// Purpose: Shared types of the port 9 alternate-function select block
// Assumes: Constants live in p9fs_consts.svh
// Notes:   Types only
package p9fs_pkg;
	// APB slave phase, one-hot
	typedef enum logic [1:0] {
		P9FS_IDLE = 2'b01,
		P9FS_ACC  = 2'b10
	} p9fs_phase_t;
endpackage : p9fs_pkg

/* rtl/p9fs_split_reg.sv */
// Purpose: 16-bit register reachable as a word and as two byte aliases
// Assumes: At most one write strobe class per cycle
// Notes:   Unimplemented bits stay at zero
`timescale 1ns/1ps
module p9fs_split_reg #(
	parameter logic [15:0] IMPL_MASK = 16'hFFFF,
	parameter logic [15:0] RST_VAL   = 16'h0000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_full,
	input  wire logic [1:0]  wr_strb,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [15:0] wdata,
	output logic      [15:0] q
);
	logic [15:0] q_r;
	logic [15:0] q_nxt;

	// Elaboration guard: an empty register makes no sense
	if (IMPL_MASK == 16'h0000) begin : g_chk
		$error("p9fs_split_reg: IMPL_MASK must not be zero");
	end

	// Merge of word, lower alias and upper alias writes
	always_comb begin
		q_nxt = q_r;
		if (wr_full && wr_strb[0]) begin
			q_nxt[7:0] = wdata[7:0];
		end
		if (wr_full && wr_strb[1]) begin
			q_nxt[15:8] = wdata[15:8];
		end
		if (wr_lo) begin
			q_nxt[7:0] = wdata[7:0];
		end
		if (wr_hi) begin
			q_nxt[15:8] = wdata[7:0]; // Alias low byte lands on upper half
		end
		q_nxt = q_nxt & IMPL_MASK; // Missing bits never hold a one
	end

	// Storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= RST_VAL & IMPL_MASK;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule : p9fs_split_reg

/* rtl/p9fs_top.sv */
// Purpose: Port 9 pin function select: mode, output type and alternate routing
// Assumes: Port latch and direction come from the port block, pins synchronous
// Notes:   Pin and peripheral outputs are registered, so routing lags one cycle
`timescale 1ns/1ps
`include "p9fs_consts.svh"
module p9fs_top
	import p9fs_pkg::*;
#(
	parameter int PIN_W = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic                  pready,
	output logic      [31:0]      prdata,
	output logic                  pslverr,
	input  wire logic [PIN_W-1:0] port_latch_bit,
	input  wire logic [PIN_W-1:0] port_dir_in,
	input  wire logic [PIN_W-1:0] pin_di,
	output logic      [PIN_W-1:0] pin_do,
	output logic      [PIN_W-1:0] pin_oe,
	input  wire logic             uart_tx_out,
	input  wire logic             timer_out,
	input  wire logic             csi_data_out,
	input  wire logic             csi_clock_io_drv,
	input  wire logic             csi_clock_io_en,
	output logic                  csi_clock_io_rcv,
	output logic                  csi_data_in,
	output logic                  uart_rx_in,
	output logic                  key_return_in_7,
	output logic                  key_return_in_6,
	output logic                  ext_irq_in_4,
	output logic                  ext_irq_in_5,
	output logic                  ext_irq_in_6
);
	p9fs_phase_t       phase_r;
	logic              pready_r;
	logic [31:0]       prdata_r;
	logic              pslverr_r;
	logic [7:0]        ots_r;
	logic [15:0]       pin_mode_control_reg;
	logic [15:0]       alt_function_select;
	logic              acc_fire;
	logic              wr_fire;
	logic [29:0]       widx;
	logic [PIN_W-1:0]  pin_do_nxt;
	logic [PIN_W-1:0]  pin_oe_nxt;
	logic [PIN_W-1:0]  pin_do_r;
	logic [PIN_W-1:0]  pin_oe_r;
	logic [7:0]        periph_r;
	logic [31:0]       rd_mux;
	logic              rd_hit;

	// Elaboration guard: routing is fixed to a 16-pin port
	if (PIN_W != 16) begin : g_chk
		$error("p9fs_top: PIN_W must be 16");
	end

	// Word index match against a register
	function automatic logic idx_hit(input logic [31:0] a, input logic [29:0] idx);
		idx_hit = (a[31:2] == idx);
	endfunction : idx_hit

	// Pin selected for its second alternate function
	function automatic logic alt_on(input logic [15:0] m, input logic [15:0] f, input int n);
		alt_on = m[n] && f[n];
	endfunction : alt_on

	assign widx     = paddr[31:2];
	assign acc_fire = psel && penable && pready_r;
	assign wr_fire  = acc_fire && pwrite;

	// APB phase; answer one cycle after setup so the response comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r  <= P9FS_IDLE;
			pready_r <= 1'b0;
		end else begin
			unique case (phase_r)
				P9FS_IDLE: begin
					if (psel && !penable) begin
						phase_r  <= P9FS_ACC;
						pready_r <= 1'b1;
					end
				end
				P9FS_ACC: begin
					phase_r  <= P9FS_IDLE;
					pready_r <= 1'b0;
				end
			endcase
		end
	end

	// Read decode; reserved bits come back as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		if (idx_hit(paddr, `P9FS_IDX_OTS)) begin
			rd_mux[7:0] = ots_r;
		end else if (idx_hit(paddr, `P9FS_IDX_PMC)) begin
			rd_mux[15:0] = pin_mode_control_reg;
		end else if (idx_hit(paddr, `P9FS_IDX_PMC_LO)) begin
			rd_mux[7:0] = pin_mode_control_reg[7:0];
		end else if (idx_hit(paddr, `P9FS_IDX_PMC_HI)) begin
			rd_mux[7:0] = pin_mode_control_reg[15:8];
		end else if (idx_hit(paddr, `P9FS_IDX_PFC)) begin
			rd_mux[15:0] = alt_function_select;
		end else if (idx_hit(paddr, `P9FS_IDX_PFC_LO)) begin
			rd_mux[7:0] = alt_function_select[7:0];
		end else if (idx_hit(paddr, `P9FS_IDX_PFC_HI)) begin
			rd_mux[7:0] = alt_function_select[15:8];
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read data and error captured at setup, held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (phase_r == P9FS_IDLE && psel && !penable) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_r <= !rd_hit; // Unmapped word answers with an error
		end else if (phase_r == P9FS_ACC) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	// Output-type register, only bits for pins 8 and 9 exist
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ots_r <= `P9FS_OTS_RST;
		end else if (wr_fire && idx_hit(paddr, `P9FS_IDX_OTS) && pstrb[0]) begin
			ots_r <= pwdata[7:0] & `P9FS_OTS_MASK;
		end
	end

	// Mode-control register with byte aliases
	p9fs_split_reg #(
		.IMPL_MASK (`P9FS_PIN_MASK),
		.RST_VAL   (`P9FS_PMC_RST)
	) u_pmc (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_full (wr_fire && idx_hit(paddr, `P9FS_IDX_PMC)),
		.wr_strb (pstrb[1:0]),
		.wr_lo   (wr_fire && idx_hit(paddr, `P9FS_IDX_PMC_LO) && pstrb[0]),
		.wr_hi   (wr_fire && idx_hit(paddr, `P9FS_IDX_PMC_HI) && pstrb[0]),
		.wdata   (pwdata[15:0]),
		.q       (pin_mode_control_reg)
	);

	// Function-control register with byte aliases
	p9fs_split_reg #(
		.IMPL_MASK (`P9FS_PIN_MASK),
		.RST_VAL   (`P9FS_PFC_RST)
	) u_pfc (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_full (wr_fire && idx_hit(paddr, `P9FS_IDX_PFC)),
		.wr_strb (pstrb[1:0]),
		.wr_lo   (wr_fire && idx_hit(paddr, `P9FS_IDX_PFC_LO) && pstrb[0]),
		.wr_hi   (wr_fire && idx_hit(paddr, `P9FS_IDX_PFC_HI) && pstrb[0]),
		.wdata   (pwdata[15:0]),
		.q       (alt_function_select)
	);

	// Pin driver mux: port mode, second alternate, or undriven when half set
	always_comb begin
		logic drive;
		logic dval;
		logic od;
		pin_do_nxt = '0;
		pin_oe_nxt = '0;
		drive = 1'b0;
		dval = 1'b0;
		od = 1'b0;
		for (int n = 0; n < PIN_W; n++) begin
			drive = 1'b0;
			dval  = 1'b0;
			if (!pin_mode_control_reg[n]) begin
				drive = !port_dir_in[n];
				dval  = port_latch_bit[n];
			end else if (alt_function_select[n]) begin
				unique case (n)
					`P9FS_PIN_TX: begin
						drive = 1'b1;
						dval  = uart_tx_out;
					end
					`P9FS_PIN_TMR: begin
						drive = 1'b1;
						dval  = timer_out;
					end
					`P9FS_PIN_SOUT: begin
						drive = 1'b1;
						dval  = csi_data_out;
					end
					`P9FS_PIN_SCK: begin
						drive = csi_clock_io_en;
						dval  = csi_clock_io_drv;
					end
					default: begin
						drive = 1'b0; // Input functions leave the pin free
						dval  = 1'b0;
					end
				endcase
			end
			// Mode set with function bit clear falls through undriven
			// Explicit compares keep the type index in range for every pin
			od = (n == `P9FS_OD_BASE && ots_r[0]) ||
				(n == `P9FS_OD_BASE + 1 && ots_r[1]);
			if (od) begin
				pin_oe_nxt[n] = drive && !dval; // Only pulls low
				pin_do_nxt[n] = 1'b0;
			end else begin
				pin_oe_nxt[n] = drive; // Push-pull
				pin_do_nxt[n] = dval;
			end
		end
		pin_oe_nxt = pin_oe_nxt & `P9FS_PIN_MASK;
		pin_do_nxt = pin_do_nxt & `P9FS_PIN_MASK;
	end

	// Registered pin drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_do_r <= '0;
			pin_oe_r <= '0;
		end else begin
			pin_do_r <= pin_do_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	// Peripheral inputs; idle levels chosen inactive when not routed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_r <= `P9FS_PERIPH_RST;
		end else begin
			periph_r[0] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_RX) ?
				pin_di[`P9FS_PIN_RX] : 1'b1;
			periph_r[1] <= pin_mode_control_reg[`P9FS_PIN_RX] ?
				1'b1 : pin_di[`P9FS_PIN_RX]; // Key return while in port mode
			periph_r[2] <= pin_mode_control_reg[`P9FS_PIN_TX] ?
				1'b1 : pin_di[`P9FS_PIN_TX];
			periph_r[3] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_SIN) ?
				pin_di[`P9FS_PIN_SIN] : 1'b1;
			periph_r[4] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_SCK) ?
				pin_di[`P9FS_PIN_SCK] : 1'b1;
			periph_r[5] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_IRQ4) &&
				pin_di[`P9FS_PIN_IRQ4];
			periph_r[6] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_IRQ5) &&
				pin_di[`P9FS_PIN_IRQ5];
			periph_r[7] <= alt_on(pin_mode_control_reg, alt_function_select, `P9FS_PIN_IRQ6) &&
				pin_di[`P9FS_PIN_IRQ6];
		end
	end

	assign pready           = pready_r;
	assign prdata           = prdata_r;
	assign pslverr          = pslverr_r;
	assign pin_do           = pin_do_r;
	assign pin_oe           = pin_oe_r;
	assign uart_rx_in       = periph_r[0];
	assign key_return_in_7  = periph_r[1];
	assign key_return_in_6  = periph_r[2];
	assign csi_data_in      = periph_r[3];
	assign csi_clock_io_rcv = periph_r[4];
	assign ext_irq_in_4     = periph_r[5];
	assign ext_irq_in_5     = periph_r[6];
	assign ext_irq_in_6     = periph_r[7];

	// Checks
	sequence s_wr(logic [29:0] idx);
		psel && penable && pready && pwrite && widx == idx;
	endsequence

	property p_ots_write;
		@(posedge pclk) disable iff (!presetn)
		s_wr(`P9FS_IDX_OTS) ##0 pstrb[0] |=> ots_r == ($past(pwdata[7:0]) & 8'h03);
	endproperty
	a_ots_write: assert property (p_ots_write) else $error("output type write wrong");

	property p_pmc_hi;
		@(posedge pclk) disable iff (!presetn)
		s_wr(`P9FS_IDX_PMC_HI) ##0 pstrb[0] |=> pin_mode_control_reg[15:8] ==
			($past(pwdata[7:0]) & 8'hE3) && $stable(pin_mode_control_reg[7:0]);
	endproperty
	a_pmc_hi: assert property (p_pmc_hi) else $error("mode upper alias wrong");

	property p_pmc_full;
		@(posedge pclk) disable iff (!presetn)
		s_wr(`P9FS_IDX_PMC) ##0 pstrb[1:0] == 2'b11 |=>
			pin_mode_control_reg == ($past(pwdata[15:0]) & 16'hE3C3);
	endproperty
	a_pmc_full: assert property (p_pmc_full) else $error("mode word write wrong");

	property p_pfc_hi;
		@(posedge pclk) disable iff (!presetn)
		s_wr(`P9FS_IDX_PFC_HI) ##0 pstrb[0] |=> alt_function_select[15:8] ==
			($past(pwdata[7:0]) & 8'hE3) && $stable(alt_function_select[7:0]);
	endproperty
	a_pfc_hi: assert property (p_pfc_hi) else $error("function upper alias wrong");

	property p_pfc_lo_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && widx == `P9FS_IDX_PFC_LO |=>
			prdata == {24'h000000, $past(alt_function_select[7:0])};
	endproperty
	a_pfc_lo_read: assert property (p_pfc_lo_read) else $error("function lower read");

	property p_pfc_unimpl;
		@(posedge pclk) disable iff (!presetn)
		(alt_function_select & 16'h1C3C) == 16'h0000;
	endproperty
	a_pfc_unimpl: assert property (p_pfc_unimpl) else $error("reserved function bit");

	property p_od_low_only;
		@(posedge pclk) disable iff (!presetn)
		ots_r[0] && !pin_mode_control_reg[8] && !port_dir_in[8] |=>
			pin_oe[8] == !$past(port_latch_bit[8]) && !pin_do[8];
	endproperty
	a_od_low_only: assert property (p_od_low_only) else $error("open drain drive");

	property p_half_alt;
		@(posedge pclk) disable iff (!presetn)
		pin_mode_control_reg[0] && !alt_function_select[0] |=> !pin_oe[0];
	endproperty
	a_half_alt: assert property (p_half_alt) else $error("half selected pin driven");

	property p_irq6;
		@(posedge pclk) disable iff (!presetn)
		pin_mode_control_reg[15] && alt_function_select[15] |=> ext_irq_in_6 == $past(pin_di[15]);
	endproperty
	a_irq6: assert property (p_irq6) else $error("irq 6 routing");

	property p_tx;
		@(posedge pclk) disable iff (!presetn)
		pin_mode_control_reg[0] && alt_function_select[0] |=>
			pin_oe[0] && pin_do[0] == $past(uart_tx_out);
	endproperty
	a_tx: assert property (p_tx) else $error("uart tx routing");

	property p_rx_mode;
		@(posedge pclk) disable iff (!presetn)
		!pin_mode_control_reg[1] |=> uart_rx_in && key_return_in_7 == $past(pin_di[1]);
	endproperty
	a_rx_mode: assert property (p_rx_mode) else $error("pin 1 port mode routing");
endmodule : p9fs_top

/* test/p9fs_far_model.sv */
// Purpose: Far side of port 9: external pin levels and peripheral outputs
// Assumes: Bench supplies external levels and peripheral values per cycle
// Notes:   A pin the block drives shows its driven level, else the outside level
`timescale 1ns/1ps
module p9fs_far_model (
	input  wire logic [15:0] pin_do,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] ext_lvl,
	input  wire logic [4:0]  per_bits,
	output logic      [15:0] pin_di,
	output logic             uart_tx_out,
	output logic             timer_out,
	output logic             csi_data_out,
	output logic             csi_clock_io_drv,
	output logic             csi_clock_io_en
);
	// Wire level: block drive wins, released pins follow the outside world
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_di[i] = pin_oe[i] ? pin_do[i] : ext_lvl[i];
		end
	end
	// Peripheral outputs, fresh each stimulus step
	assign uart_tx_out      = per_bits[0];
	assign timer_out        = per_bits[1];
	assign csi_data_out     = per_bits[2];
	assign csi_clock_io_drv = per_bits[3];
	assign csi_clock_io_en  = per_bits[4];
endmodule : p9fs_far_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the port 9 function select block
// Assumes: Single-cycle APB slave, byte address is four times the word index
// Notes:   Read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`include "p9fs_consts.svh"
module testbench import p9fs_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0]  pstrb;
	logic [15:0] port_latch_bit, port_dir_in, pin_di, pin_do, pin_oe, ext, m;
	logic [4:0]  per;
	logic        tx, tmr, sdo, ckd, cke, ckr, sdi, urx, kr7, kr6, ir4, ir5, ir6;
	logic [32:0] exp_q[$];
	logic [32:0] exp_w;
	logic [29:0] base;
	logic [31:0] v, u;
	int          mismatches, comparisons, seed;
	p9fs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .port_latch_bit(port_latch_bit),
		.port_dir_in(port_dir_in), .pin_di(pin_di), .pin_do(pin_do), .pin_oe(pin_oe),
		.uart_tx_out(tx), .timer_out(tmr), .csi_data_out(sdo), .csi_clock_io_drv(ckd),
		.csi_clock_io_en(cke), .csi_clock_io_rcv(ckr), .csi_data_in(sdi), .uart_rx_in(urx),
		.key_return_in_7(kr7), .key_return_in_6(kr6), .ext_irq_in_4(ir4),
		.ext_irq_in_5(ir5), .ext_irq_in_6(ir6));
	p9fs_far_model far_u (.pin_do(pin_do), .pin_oe(pin_oe), .ext_lvl(ext), .per_bits(per),
		.pin_di(pin_di), .uart_tx_out(tx), .timer_out(tmr), .csi_data_out(sdo),
		.csi_clock_io_drv(ckd), .csi_clock_io_en(cke));
	// Clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] ex);
		comparisons++;
		if (got !== ex) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, ex);
		end
	endtask : chk
	task automatic final_report();
		if (mismatches == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	// One APB transfer; the expected answer is queued before the request
	task automatic xfer(input logic wr_en, input logic [29:0] idx, input logic [31:0] wd,
			input logic [3:0] sb, input logic [32:0] ex);
		int n;
		exp_q.push_back(ex);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		pstrb   <= sb;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 16) mismatches++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [29:0] idx, input logic [15:0] d, input logic [3:0] sb);
		xfer(1'b1, idx, {16'h0000, d}, sb, 33'h000000000);
	endtask : wr
	task automatic rd(input logic [29:0] idx, input logic [15:0] e);
		xfer(1'b0, idx, 32'h00000000, 4'hF, {17'h00000, e});
	endtask : rd
	task automatic pchk(input logic [15:0] got, input logic [15:0] ex);
		chk({17'h00000, got}, {17'h00000, ex});
	endtask : pchk
	// Fresh pin and peripheral values, then let both register stages settle
	task automatic run(input int k);
		repeat (4) begin
			ext <= 16'($random(seed));
			per <= 5'($random(seed));
			// Port-mode pass also shakes direction and latch
			if (k == 4) begin
				port_dir_in    <= 16'($random(seed));
				port_latch_bit <= 16'($random(seed));
			end
			repeat (3) @(posedge pclk);
			#1;
			case (k)
				0: begin
					pchk(pin_oe & 16'hE3C3, 16'h0141 | {6'h00, per[4], 9'h000});
					pchk({13'h0000, pin_do[8], pin_do[6], pin_do[0]}, {13'h0000, per[2:0]});
					pchk({15'h0000, pin_do[9]}, {15'h0000, per[3]});
					pchk({15'h0000, ckr}, {15'h0000, per[4] ? per[3] : ext[9]});
					pchk({12'h000, ir6, ir5, ir4, urx}, {12'h000, ext[15:13], ext[1]});
					pchk({14'h0000, sdi, kr7}, {14'h0000, ext[7], 1'b1});
				end
				1: begin
					pchk({14'h0000, pin_oe[8], pin_do[8]}, {14'h0000, ~per[2], 1'b0});
					pchk({14'h0000, pin_oe[9], pin_do[9]}, {14'h0000, per[4] & ~per[3], 1'b0});
				end
				2: pchk({13'h0000, pin_oe[6], pin_oe[0], urx}, 16'h0001);
				3: pchk({13'h0000, kr7, kr6, urx}, {13'h0000, ext[1:0], 1'b1});
				default: begin
					// Port mode: direction drives, pins 8 and 9 only pull low
					pchk(pin_oe, ~port_dir_in & 16'hE3C3 & ~(port_latch_bit & 16'h0300));
					pchk(pin_do, port_latch_bit & 16'hE0C3);
					pchk({10'h000, ir6, ir5, ir4, sdi, ckr, urx}, 16'h0007);
					pchk({15'h0000, kr7}, {15'h0000, port_dir_in[1] ? ext[1] : port_latch_bit[1]});
				end
			endcase
			@(posedge pclk);
		end
	endtask : run
	// Monitor: each answer is matched with the oldest queued expectation
	always @(posedge pclk) begin
		if (presetn === 1'b1 && pready === 1'b1) begin
			if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1FFFFFFFF);
			else begin
				exp_w = exp_q.pop_front();
				chk({pslverr, prdata}, exp_w);
			end
		end
	end
	// Watchdog, far beyond the fewer than 500 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		final_report();
	end
	initial begin
		seed = 98562;
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		port_latch_bit = 16'h0000;
		port_dir_in    = 16'hFFFF;
		ext = 16'h0000;
		per = 5'h00;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values of every word, then an unmapped word is refused
		rd(`P9FS_IDX_OTS, 16'h0000);
		for (int j = 0; j < 2; j++) begin
			base = j ? `P9FS_IDX_PFC : `P9FS_IDX_PMC;
			rd(base, 16'h0000);
			rd(base + 30'd4, 16'h0000);
			rd(base + 30'd5, 16'h0000);
		end
		xfer(1'b1, 30'h0FFFFC41, 32'h0000FFFF, 4'hF, {1'b1, 32'h0});
		xfer(1'b0, 30'h0FFFFC41, 32'h0, 4'hF, {1'b1, 32'h0});
		// Word and byte-alias views of mode and function registers
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 2; j++) begin
				base = j ? `P9FS_IDX_PFC : `P9FS_IDX_PMC;
				v = $random(seed);
				u = $random(seed);
				m = v[15:0] & `P9FS_PIN_MASK;
				wr(base, v[15:0], 4'h3);
				rd(base, m);
				rd(base + 30'd4, {8'h00, m[7:0]});
				rd(base + 30'd5, {8'h00, m[15:8]});
				wr(base + 30'd5, {8'h00, u[7:0]}, 4'h1);
				m[15:8] = u[7:0] & 8'hE3;
				rd(base, m);
				wr(base + 30'd4, {8'h00, u[15:8]}, 4'h1);
				m[7:0] = u[15:8] & 8'hC3;
				rd(base, m);
			end
		end
		wr(`P9FS_IDX_OTS, 16'h00FF, 4'h1);
		rd(`P9FS_IDX_OTS, 16'h0003);
		// Latch, function, output type, then mode, in that order
		port_latch_bit <= 16'hFFFF;
		@(posedge pclk);
		wr(`P9FS_IDX_PFC, 16'hFFFF, 4'h3);
		wr(`P9FS_IDX_OTS, 16'h0000, 4'h1);
		wr(`P9FS_IDX_PMC, 16'hFFFF, 4'h3);
		run(0);
		wr(`P9FS_IDX_OTS, 16'h0003, 4'h1);
		run(1);
		wr(`P9FS_IDX_PFC_LO, 16'h0000, 4'h1);
		run(2);
		wr(`P9FS_IDX_PMC_LO, 16'h0000, 4'h1);
		run(3);
		wr(`P9FS_IDX_PMC, 16'h0000, 4'h3);
		run(4);
		repeat (4) @(posedge pclk);
		if (exp_q.size() != 0) mismatches++;
		final_report();
	end
endmodule : testbench
